/* File: rtl/hpfc_consts.vh */
/*
 header of constants for the packet-link check control block:
 register offsets, field positions, reset values, frame marks and crc parameters.
 assumes inclusion by bare name from the design file; definitions only.
*/
`ifndef HPFC_CONSTS_VH
`define HPFC_CONSTS_VH
`define HPFC_IDX_CHECK_CTRL   12'h005
`define HPFC_IDX_FEATURE      12'h004
`define HPFC_IDX_MODE         12'h000
`define HPFC_OFF_CHECK_CTRL   (`HPFC_IDX_CHECK_CTRL << 2)
`define HPFC_OFF_FEATURE      (`HPFC_IDX_FEATURE << 2)
`define HPFC_OFF_MODE         (`HPFC_IDX_MODE << 2)
`define HPFC_OFF_STATUS       12'h008
`define HPFC_CTRL_WMASK       8'hFE
`define HPFC_FEAT_WMASK       8'h08
`define HPFC_MODE_WMASK       8'h08
`define HPFC_CTRL_RST         8'h00
`define HPFC_LIMIT_HI         7
`define HPFC_LIMIT_LO         4
`define HPFC_LIMIT_EN_BIT     3
`define HPFC_WIDE_BIT         2
`define HPFC_LINK_DIS_BIT     1
`define HPFC_PAR_EN_BIT       3
`define HPFC_E3_BIT           3
`define HPFC_FULL_LIMIT       5'h10
`define HPFC_FLAG             8'h7E
`define HPFC_CRC16_INIT       16'hFFFF
`define HPFC_CRC16_POLY       16'h8408
`define HPFC_CRC16_GOOD       16'hF0B8
`define HPFC_WIDE_CHECK_SELECT_INIT       32'hFFFFFFFF
`define HPFC_WIDE_CHECK_SELECT_POLY       32'hEDB88320
`define HPFC_WIDE_CHECK_SELECT_GOOD       32'hDEBB20E3
`define HPFC_CRC16_BYTES      3'h2
`define HPFC_WIDE_CHECK_SELECT_BYTES      3'h4
`define HPFC_RDATA_ZERO       32'h00000000
`endif

/* File: rtl/hpfc_top.v */
/*
 packet-link check control: apb register file, byte-wise fcs generation on the
 transmit bytes and fcs checking on the receive bytes, with limited-length mode.
 assumes apb master on clk; byte strobes arrive on a foreign byte clock that is
 sampled here; host keeps send strobes high for the fcs byte count.
*/
// How it works
// - the byte limit comes from control bits 7..4, with zero meaning sixteen bytes.
// - with limit enable set the check covers only the first N bytes of each frame.
// - with limit enable clear the check covers every byte of the frame.
// - wide select high uses the 32-bit check for both sending and checking.
// - wide select low uses the 16-bit check for both sending and checking.
// - with e3 external overhead the receive byte clock has gaps, so only real edges count.
// - with link disable set, no payload is taken or checked, in e3 mode or not.
// - in limited mode the sent check is frozen after N bytes and appended normally.
// - in limited mode the receiver compares its held check with the last 2 or 4 bytes.
`timescale 1ns/1ps
`include "hpfc_consts.vh"
module hpfc_top
(
  input  wire        clk,
  input  wire        arst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  input  wire        tx_byte_clk,
  input  wire [7:0]  tx_data,
  input  wire        send_message_strobe,
  input  wire        send_check_strobe,
  output reg  [7:0]  tx_line_data,
  output reg         tx_line_valid,
  input  wire        tx_line_ready,
  output wire        tx_data_ready,
  input  wire        rx_byte_clk,
  input  wire [7:0]  rx_data,
  input  wire        rx_idle,
  output reg         rx_check_valid,
  output reg         rx_check_done,
  output wire        packet_link_disable,
  output wire        e3_frame_select
);
  reg  [7:0]  ctrl_q;
  reg         par_en_q;
  reg         e3_q;
  reg  [1:0]  tck_s;
  reg         tck_d1_q;
  reg  [1:0]  rck_s;
  reg         rck_d1_q;
  reg  [7:0]  td_s0;
  reg  [7:0]  td_s1;
  reg  [1:0]  tmsg_s;
  reg  [1:0]  tfcs_s;
  reg  [7:0]  rd_s0;
  reg  [7:0]  rd_s1;
  reg  [1:0]  ridle_s;
  reg  [31:0] tcrc_q;
  reg  [4:0]  tcnt_q;
  reg         tin_q;
  reg  [2:0]  tfb_q;
  reg  [31:0] rcrc_q;
  reg  [31:0] r_shadow_q;
  reg  [31:0] rwin_q;
  reg  [4:0]  rcnt_q;
  reg         rin_q;
  reg  [7:0]  buf_d0_q;
  reg  [7:0]  buf_d1_q;
  reg  [1:0]  buf_n_q;
  reg         tx_drop_q;
  wire        wide    = ctrl_q[`HPFC_WIDE_BIT];
  wire        lim_en  = ctrl_q[`HPFC_LIMIT_EN_BIT];
  wire [3:0]  lim_fld = ctrl_q[`HPFC_LIMIT_HI:`HPFC_LIMIT_LO];
  wire [4:0]  lim_n   = (lim_fld == 4'h0) ? `HPFC_FULL_LIMIT : {1'b0, lim_fld};
  wire        active  = par_en_q & ~packet_link_disable;
  wire        tck_rise = tck_s[1] & ~tck_d1_q;
  wire        rck_rise = rck_s[1] & ~rck_d1_q;
  wire        wr = psel & penable & pwrite;
  wire [2:0]  fcs_bytes = wide ? `HPFC_WIDE_CHECK_SELECT_BYTES : `HPFC_CRC16_BYTES;
  wire        buf_full  = (buf_n_q == 2'h2);
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign packet_link_disable = ctrl_q[`HPFC_LINK_DIS_BIT];
  assign e3_frame_select     = e3_q;
  assign tx_data_ready       = ~buf_full;
  // lsb-first crc over one byte, reflected polynomials
  function [31:0] crc_byte;
    input [31:0] c;
    input [7:0]  d;
    input        w;
    integer      i;
    reg   [31:0] r;
    begin
      r = c ^ {24'h000000, d};
      for (i = 0; i < 8; i = i + 1)
      begin
        if (w)
          r = r[0] ? ((r >> 1) ^ `HPFC_WIDE_CHECK_SELECT_POLY) : (r >> 1);
        else
          r = r[0] ? ({16'h0000, r[15:1]} ^ {16'h0000, `HPFC_CRC16_POLY}) : {16'h0000, r[15:1]};
      end
      crc_byte = r;
    end
  endfunction
  // registers; reserved bits masked so they always read zero
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_q   <= `HPFC_CTRL_RST;
      par_en_q <= 1'b0;
      e3_q     <= 1'b0;
    end
    else if (wr)
    begin
      if (paddr == `HPFC_OFF_CHECK_CTRL)
        ctrl_q <= pwdata[7:0] & `HPFC_CTRL_WMASK;
      if (paddr == `HPFC_OFF_FEATURE)
        par_en_q <= pwdata[`HPFC_PAR_EN_BIT];
      if (paddr == `HPFC_OFF_MODE)
        e3_q <= pwdata[`HPFC_E3_BIT];
    end
  end
  always @*
  begin
    prdata = `HPFC_RDATA_ZERO;
    case (paddr)
      `HPFC_OFF_CHECK_CTRL: prdata = {24'h000000, ctrl_q};
      `HPFC_OFF_FEATURE:    prdata = {28'h0000000, par_en_q, 3'h0};
      `HPFC_OFF_MODE:       prdata = {28'h0000000, e3_q, 3'h0};
      `HPFC_OFF_STATUS:     prdata = {27'h0000000, tx_drop_q, buf_n_q, rx_check_done, rx_check_valid};
      default:              prdata = `HPFC_RDATA_ZERO;
    endcase
  end
  // two-stage synchronisers on all byte-link inputs
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tck_s <= 2'h0;  tck_d1_q <= 1'b0;
      rck_s <= 2'h0;  rck_d1_q <= 1'b0;
      td_s0 <= 8'h00; td_s1 <= 8'h00;
      rd_s0 <= 8'h00; rd_s1 <= 8'h00;
      tmsg_s <= 2'h0; tfcs_s <= 2'h0; ridle_s <= 2'h0;
    end
    else
    begin
      tck_s <= {tck_s[0], tx_byte_clk};
      tck_d1_q <= tck_s[1];
      rck_s <= {rck_s[0], rx_byte_clk};
      rck_d1_q <= rck_s[1];
      td_s0 <= tx_data;
      td_s1 <= td_s0;
      rd_s0 <= rx_data;
      rd_s1 <= rd_s0;
      tmsg_s <= {tmsg_s[0], send_message_strobe};
      tfcs_s <= {tfcs_s[0], send_check_strobe};
      ridle_s <= {ridle_s[0], rx_idle};
    end
  end
  // transmit: crc, limit counter, check-byte emission into a two-entry buffer
  wire        t_msg   = tmsg_s[1] & ~tfcs_s[1];
  wire        t_fcs   = tmsg_s[1] & tfcs_s[1];
  wire        t_count = ~lim_en | (tcnt_q < lim_n);
  wire [31:0] t_fin   = ~tcrc_q;
  wire [4:0]  t_sh    = {tfb_q[1:0], 3'h0};
  wire [31:0] t_shv   = t_fin >> t_sh;
  wire [7:0]  t_byte  = t_fcs ? t_shv[7:0] : (t_msg ? td_s1 : `HPFC_FLAG);
  wire        t_push  = tck_rise & active;
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tcrc_q <= `HPFC_WIDE_CHECK_SELECT_INIT;
      tcnt_q <= 5'h00;
      tin_q  <= 1'b0;
      tfb_q  <= 3'h0;
      tx_drop_q <= 1'b0;
    end
    else if (t_push)
    begin
      tx_drop_q <= tx_drop_q | buf_full;
      if (t_msg)
      begin
        tin_q <= 1'b1;
        tfb_q <= 3'h0;
        if (!tin_q)
        begin
          tcrc_q <= crc_byte(wide ? `HPFC_WIDE_CHECK_SELECT_INIT : {16'h0000, `HPFC_CRC16_INIT}, td_s1, wide);
          tcnt_q <= 5'h01;
        end
        else if (t_count)
        begin
          tcrc_q <= crc_byte(tcrc_q, td_s1, wide);
          tcnt_q <= tcnt_q + 5'h01;
        end
      end
      else if (t_fcs)
      begin
        tfb_q <= (tfb_q + 3'h1 == fcs_bytes) ? 3'h0 : tfb_q + 3'h1;
        tin_q <= (tfb_q + 3'h1 != fcs_bytes);
      end
      else
      begin
        tin_q <= 1'b0;
        tcnt_q <= 5'h00;
      end
    end
  end
  // two-entry buffer; stalls by the line side lose nothing while not full
  wire buf_pop = tx_line_valid & tx_line_ready;
  wire buf_ins = t_push & ~buf_full;
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      buf_d0_q <= 8'h00;
      buf_d1_q <= 8'h00;
      buf_n_q  <= 2'h0;
    end
    else
    begin
      if (buf_pop)
        buf_d0_q <= buf_d1_q;
      if (buf_ins)
      begin
        if (buf_n_q == 2'h0 || (buf_n_q == 2'h1 && buf_pop))
          buf_d0_q <= t_byte;
        else
          buf_d1_q <= t_byte;
      end
      buf_n_q <= buf_n_q + {1'b0, buf_ins} - {1'b0, buf_pop};
    end
  end
  always @*
  begin
    tx_line_valid = (buf_n_q != 2'h0);
    tx_line_data  = buf_d0_q;
  end
  // receive: crc over all bytes checked against the residue, or in limited mode over first N bytes compared with trailing 2/4 bytes at idle
  wire        r_count = ~lim_en | (rcnt_q < lim_n);
  wire [31:0] r_win16 = {16'h0000, rwin_q[31:16]};
  // held check is read before its copy into rcrc_q lands at frame end
  wire        r_ok    = wide ? (~r_shadow_q == rwin_q) : ((~r_shadow_q[15:0]) == r_win16[15:0]);
  reg  [31:0] r_full_q;
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rcrc_q <= `HPFC_WIDE_CHECK_SELECT_INIT;
      r_full_q <= `HPFC_WIDE_CHECK_SELECT_INIT;
      r_shadow_q <= `HPFC_RDATA_ZERO;
      rwin_q <= `HPFC_RDATA_ZERO;
      rcnt_q <= 5'h00;
      rin_q  <= 1'b0;
      rx_check_valid <= 1'b0;
      rx_check_done  <= 1'b0;
    end
    else if (rck_rise & active)
    begin
      if (!ridle_s[1])
      begin
        if (!rin_q)
        begin
          rcrc_q <= `HPFC_WIDE_CHECK_SELECT_INIT;
          r_full_q <= crc_byte(wide ? `HPFC_WIDE_CHECK_SELECT_INIT : {16'h0000, `HPFC_CRC16_INIT}, rd_s1, wide);
          r_shadow_q <= wide ? `HPFC_WIDE_CHECK_SELECT_INIT : {16'h0000, `HPFC_CRC16_INIT};
          rcnt_q <= 5'h01;
          rx_check_valid <= 1'b0;
          rx_check_done  <= 1'b0;
        end
        else
        begin
          r_full_q <= crc_byte(r_full_q, rd_s1, wide);
          if (r_count)
            rcnt_q <= rcnt_q + 5'h01;
        end
        // limited check takes the first N bytes received, so trailing bytes enter it when the message is shorter than N
        if (lim_en && ((rin_q ? rcnt_q : 5'h00) < lim_n))
          r_shadow_q <= crc_byte(rin_q ? r_shadow_q : (wide ? `HPFC_WIDE_CHECK_SELECT_INIT : {16'h0000, `HPFC_CRC16_INIT}),
                                 rd_s1, wide);
        rwin_q <= {rd_s1, rwin_q[31:8]};
        rin_q <= 1'b1;
      end
      else if (rin_q)
      begin
        rin_q <= 1'b0;
        rx_check_done  <= 1'b1;
        rx_check_valid <= lim_en ? r_ok :
                          (wide ? (r_full_q == `HPFC_WIDE_CHECK_SELECT_GOOD) :
                                  (r_full_q[15:0] == `HPFC_CRC16_GOOD));
        rcrc_q <= r_shadow_q;
      end
    end
  end
endmodule // hpfc_top

/* File: testbench/hpfc_host_model.sv */
/* host model: free byte clock and frame source, line bytes looped back to rx.
 assumes the block's clk; byte clock has 32 clk per slot. */
`timescale 1ns/1ps
module hpfc_host_model
(
  input  wire       clk,
  input  wire       stall,
  input  wire [4:0] flip_idx,
  output reg        tx_byte_clk,
  output reg  [7:0] tx_data,
  output reg        send_message_strobe,
  output reg        send_check_strobe,
  input  wire [7:0] tx_line_data,
  input  wire       tx_line_valid,
  output reg        tx_line_ready,
  output reg        rx_byte_clk,
  output reg  [7:0] rx_data,
  output reg        rx_idle
);
  reg [4:0] ph_q = 5'h00;
  reg [3:0] pulse_q = 4'h0;
  reg [4:0] nth_q = 5'h00;
  integer   pops = 0;
  initial {tx_byte_clk, tx_data, send_message_strobe, send_check_strobe, rx_byte_clk, rx_data} = 0;
  initial {tx_line_ready, rx_idle} = 2'b01;
  // rx clock only pulses per popped byte, so it has gaps
  always @(posedge clk)
  begin
    ph_q <= ph_q + 5'h01;
    tx_byte_clk <= ph_q[4];
    rx_byte_clk <= pulse_q[3];
    tx_line_ready <= !stall && pulse_q == 4'h0 && !(tx_line_valid && tx_line_ready);
    if (pulse_q != 4'h0)
      pulse_q <= pulse_q - 4'h1;
    if (tx_line_valid && tx_line_ready)
    begin
      pops = pops + 1;
      pulse_q <= 4'hF;
      rx_idle <= tx_line_data == 8'h7E;
      nth_q <= tx_line_data == 8'h7E ? 5'h00 : nth_q + 5'h01;
      rx_data <= tx_line_data ^ {7'h0, flip_idx != 5'h00 && nth_q + 5'h01 == flip_idx};
    end
  end
  task send(input integer n, input integer fb);
    integer i;
    begin
      for (i = 0; i < n + fb + 2; i = i + 1)
      begin
        @(posedge clk);
        while (ph_q != 5'h00) @(posedge clk);
        send_message_strobe <= i < n + fb;
        send_check_strobe <= i >= n && i < n + fb;
        tx_data <= 8'h30 + i[7:0];
      end
    end
  endtask
endmodule // hpfc_host_model

/* File: testbench/hpfc_monitor.sv */
/* checker on the hpfc_top ports: apb answers, control fields, line buffer.
 assumes the bind below and the single clk domain. */
`timescale 1ns/1ps
`include "hpfc_consts.vh"
module hpfc_monitor
(
  input wire        clk,
  input wire        arst_n,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire [31:0] prdata,
  input wire        pslverr,
  input wire [7:0]  tx_line_data,
  input wire        tx_line_valid,
  input wire        tx_line_ready,
  input wire        tx_data_ready,
  input wire        packet_link_disable,
  input wire        e3_frame_select
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire wr_c = psel && penable && pwrite && paddr == `HPFC_OFF_CHECK_CTRL;
  wire wr_m = psel && penable && pwrite && paddr == `HPFC_OFF_MODE;
  wire rd_c = psel && !pwrite && paddr == `HPFC_OFF_CHECK_CTRL;
  zero_wait_a: assert property (psel && penable |-> pready && !pslverr)
    else $error("apb answer late or error");
  dis_write_a: assert property (wr_c |=> packet_link_disable == $past(pwdata[1]))
    else $error("link disable not written");
  dis_hold_a: assert property (!wr_c |=> $stable(packet_link_disable))
    else $error("link disable moved");
  e3_write_a: assert property (wr_m |=> e3_frame_select == $past(pwdata[3]))
    else $error("e3 select not written");
  e3_hold_a: assert property (!wr_m |=> $stable(e3_frame_select))
    else $error("e3 select moved");
  rsvd_read_a: assert property (rd_c |-> prdata[31:8] == 24'h0 && !prdata[0])
    else $error("reserved bits read back set");
  dis_read_a: assert property (rd_c |-> prdata[1] == packet_link_disable)
    else $error("readback differs from field");
  line_hold_a: assert property (tx_line_valid && !tx_line_ready |=> tx_line_valid && $stable(tx_line_data))
    else $error("line byte lost in stall");
  full_valid_a: assert property (!tx_data_ready |-> tx_line_valid)
    else $error("full buffer shows no byte");
endmodule // hpfc_monitor
bind hpfc_top hpfc_monitor u_hpfc_monitor (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .prdata, .pslverr, .tx_line_data, .tx_line_valid, .tx_line_ready, .tx_data_ready, .packet_link_disable,
  .e3_frame_select);

/* File: testbench/tb.sv */
/* self-checking bench: registers over apb, looped frames, buffer stall.
 assumes hpfc_host_model on the byte side and a 200 MHz clk. */
`timescale 1ns/1ps
`include "hpfc_consts.vh"
module tb;
  reg         clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stall = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0, rdv;
  reg  [4:0]  flip_idx = 5'h00;
  wire [31:0] prdata;
  wire [7:0]  tx_data, tx_line_data, rx_data;
  wire        pready, pslverr, tx_byte_clk, send_message_strobe, send_check_strobe, tx_line_valid, tx_line_ready;
  wire        tx_data_ready, rx_byte_clk, rx_idle, rx_check_valid, rx_check_done, packet_link_disable;
  wire        e3_frame_select;
  integer     bad_count = 0, compares = 0, cyc = 0, p0;
  hpfc_top u_hpfc_top (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .tx_byte_clk, .tx_data, .send_message_strobe, .send_check_strobe, .tx_line_data, .tx_line_valid,
    .tx_line_ready, .tx_data_ready, .rx_byte_clk, .rx_data, .rx_idle, .rx_check_valid, .rx_check_done,
    .packet_link_disable, .e3_frame_select);
  hpfc_host_model u_hpfc_host_model (.clk, .stall, .flip_idx, .tx_byte_clk, .tx_data, .send_message_strobe,
    .send_check_strobe, .tx_line_data, .tx_line_valid, .tx_line_ready, .rx_byte_clk, .rx_data, .rx_idle);
  initial forever #2.5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      bad_count++;
      finish_test;
    end
  end
  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    begin
      compares++;
      if (got !== exp)
      begin
        $display("[ERR] %s expected %h seen %h", name, exp, got);
        bad_count++;
      end
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    integer n;
    begin
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 50) @(posedge clk) n++;
      check("pready", 32'h1, {31'h0, pready});
      rdv = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask
  task frame(input logic [7:0] ctrl, input integer n, input integer fb, input logic [4:0] fl, input logic exp);
    integer k;
    begin
      k = 0;
      apb(1'b1, `HPFC_OFF_CHECK_CTRL, {24'h0, ctrl});
      flip_idx <= fl;
      u_hpfc_host_model.send(n, fb);
      while (rx_check_done !== 1'b1 && k < 300) @(posedge clk) k++;
      check("rx_check_done", 32'h1, {31'h0, rx_check_done});
      check("rx_check_valid", {31'h0, exp}, {31'h0, rx_check_valid});
    end
  endtask
  task t_regs;
    begin
      apb(1'b0, `HPFC_OFF_CHECK_CTRL, 0);
      check("ctrl reset", 32'h0, rdv);
      apb(1'b1, `HPFC_OFF_CHECK_CTRL, 32'hFE);
      apb(1'b0, `HPFC_OFF_CHECK_CTRL, 0);
      check("ctrl readback", 32'hFE, rdv);
      check("link disable", 32'h1, {31'h0, packet_link_disable});
      apb(1'b1, `HPFC_OFF_MODE, 32'h08);
      check("e3 select", 32'h1, {31'h0, e3_frame_select});
      apb(1'b1, `HPFC_OFF_MODE, 0);
      apb(1'b1, `HPFC_OFF_CHECK_CTRL, 0);
      apb(1'b1, 12'h00C, 32'hFF);
      apb(1'b0, 12'h00C, 0);
      check("unmapped read", 32'h0, rdv);
    end
  endtask
  task t_enable;
    begin
      p0 = u_hpfc_host_model.pops;
      u_hpfc_host_model.send(3, 2);
      check("bytes taken while off", p0, u_hpfc_host_model.pops);
      apb(1'b1, `HPFC_OFF_FEATURE, 32'h08);
    end
  endtask
  task t_full;
    begin
      frame(8'h00, 5, 2, 0, 1'b1);
      frame(8'h00, 5, 2, 4, 1'b0);
      frame(8'h04, 5, 4, 0, 1'b1);
      frame(8'h04, 5, 2, 0, 1'b0);
      frame(8'h00, 5, 4, 0, 1'b0);
    end
  endtask
  task t_limit;
    begin
      frame(8'h28, 5, 2, 4, 1'b1);
      frame(8'h28, 5, 2, 2, 1'b0);
      frame(8'h08, 18, 2, 17, 1'b1);
      frame(8'h08, 18, 2, 16, 1'b0);
      frame(8'hF8, 17, 2, 16, 1'b1);
      frame(8'h2C, 5, 4, 4, 1'b1);
    end
  endtask
  task t_stall;
    integer k;
    begin
      k = 0;
      stall <= 1'b1;
      repeat (150) @(posedge clk);
      check("tx_data_ready", 32'h0, {31'h0, tx_data_ready});
      apb(1'b0, `HPFC_OFF_STATUS, 0);
      check("drop flag", 32'h1, {31'h0, rdv[4]});
      stall <= 1'b0;
      while (tx_line_valid !== 1'b0 && k < 60) @(posedge clk) k++;
      check("buffer drained", 32'h0, {31'h0, tx_line_valid});
    end
  endtask
  task finish_test;
    begin
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_regs;
    t_enable;
    t_full;
    t_limit;
    t_stall;
    finish_test;
  end
endmodule // tb
